// ### sim/rpm_adc_model.sv
// converter model answering the conversion requests of the amplitude sequencer
`timescale 1ns/100ps
`default_nettype none
module rpm_adc_model (
  input  wire logic         i_sys_clk, // device clock
  input  wire logic         i_rst,     // async reset, high
  input  wire logic         i_start,   // conversion request pulse
  input  wire logic [7:0]   i_code,    // code to return
  input  wire logic [7:0]   i_delay,   // result comes this many cycles plus one after the request
  input  wire logic         i_mute,    // never answer, forces a timeout
  output rpm_pkg::rpm_adc_t o_adc      // result strobe
);
  logic [8:0] cnt;

  // one answer per request; data toggles while idle so a stale code never looks valid
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt   <= 9'h000;
      o_adc <= '0;
    end
    else
    begin
      o_adc.valid <= 1'b0;
      o_adc.code  <= ~o_adc.code;
      if (i_start && !i_mute)
        cnt <= {1'b0, i_delay} + 9'h001;
      else if (cnt == 9'h001)
      begin
        o_adc.valid <= 1'b1;
        o_adc.code  <= i_code;
        cnt         <= 9'h000;
      end
      else if (cnt != 9'h000)
        cnt <= cnt - 9'h001;
    end
  end
endmodule // rpm_adc_model
`default_nettype wire

// ### sim/test_rpm_cmd.sv
// self-checking bench of the preset, mask and amplitude command block
`timescale 1ns/100ps
`default_nettype none
module test_rpm_cmd;
  localparam int AMP = 200; // shortened measurement timeout
  logic               i_sys_clk, i_rst, i_reg_wr, i_reg_rd, i_xtal_stable, i_mask_tmr_run;
  logic               mute, o_mask_tmr_clr, o_rx_on, o_framer_en, o_tx_on, o_amp_det_en;
  logic               o_adc_abs, o_adc_start, o_cmd_term_irq, st;
  logic [5:0]         i_reg_addr;
  logic [7:0]         i_reg_wdata, o_reg_rdata, a_code, a_dly, d;
  logic [2:0]         i_rx_rate, i_tx_rate;
  rpm_pkg::rpm_cmd_t  i_cmd;
  rpm_pkg::rpm_mode_t i_mode;
  rpm_pkg::rpm_adc_t  i_adc;
  rpm_pkg::rpm_cfg_t  o_cfg, cur, ex;
  int                 n_fail, compares, seed, n;

  rpm_cmd #(.AMP_MAX_CYC(AMP)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_cmd(i_cmd), .i_mode(i_mode), .i_rx_rate(i_rx_rate),
    .i_tx_rate(i_tx_rate), .i_xtal_stable(i_xtal_stable), .i_mask_tmr_run(i_mask_tmr_run),
    .i_adc(i_adc), .o_mask_tmr_clr(o_mask_tmr_clr), .o_rx_on(o_rx_on),
    .o_framer_en(o_framer_en), .o_tx_on(o_tx_on), .o_amp_det_en(o_amp_det_en),
    .o_adc_abs(o_adc_abs), .o_adc_start(o_adc_start), .o_cmd_term_irq(o_cmd_term_irq),
    .o_cfg(o_cfg));
  rpm_adc_model adc (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_start(o_adc_start),
    .i_code(a_code), .i_delay(a_dly), .i_mute(mute), .o_adc(i_adc));

  // free-running device clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= v;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 v = o_reg_rdata;
  endtask

  // one-cycle command strobe; returns just after the edge that takes it
  task automatic cmd(input logic [7:0] c);
    @(posedge i_sys_clk);
    i_cmd <= '{valid: 1'b1, code: c};
    @(posedge i_sys_clk);
    i_cmd.valid <= 1'b0;
    #1;
  endtask

  // bounded wait for the termination pulse, noting any conversion request on the way
  task automatic wait_irq();
    n  = 0;
    st = 1'b0;
    while (o_cmd_term_irq !== 1'b1 && n < 400)
    begin
      @(posedge i_sys_clk);
      #1 n++;
      if (o_adc_start === 1'b1)
        st = 1'b1;
    end
  endtask

  // expected registers after a preset, from the prior values, mode and rates
  function automatic rpm_pkg::rpm_cfg_t pre(input rpm_pkg::rpm_cfg_t c, input logic [3:0] m,
                                             input logic [2:0] rx, input logic [2:0] tx);
    logic nfc;
    nfc = (m == 4'h5) || (m == 4'h6);
    if (nfc)
      c.op_ctrl[5] = 1'b1;
    if (nfc || m == 4'h7 || m == 4'h8)
      c.op_ctrl[3] = 1'b0;
    c.type_a[5] = nfc;
    if (m == 4'h0 || m == 4'h4 || (nfc && tx == 3'h0))
      c.aux[5] = 1'b0;
    else if (m == 4'h1 || m == 4'h3 || nfc)
      c.aux[5] = 1'b1;
    c.aux[4] = nfc;
    if (nfc)
      c.rx_one[7] = 1'b0;
    c.rx_one[6] = (rx > 3'h3);
    c.rx_one[5:0] = nfc ? 6'h02 : rx == 3'h0 ? 6'h04 : rx == 3'h1 ? 6'h0c :
                    rx == 3'h2 ? 6'h14 : rx == 3'h3 ? 6'h24 : 6'h00;
    c.rx_three[1:0] = {nfc, nfc};
    return c;
  endfunction

  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs under a thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end

  // main sequence
  initial
  begin
    seed = 85955;
    n_fail = 0;
    compares = 0;
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_cmd, i_rx_rate, i_tx_rate} = '0;
    {i_xtal_stable, i_mask_tmr_run, mute, a_code, a_dly} = '0;
    i_mode = rpm_pkg::RPM_MODE_ISO_A;
    i_rst = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk(o_cfg, 40'h0);
    chk({o_rx_on, o_tx_on, o_cmd_term_irq, o_adc_start}, 4'h0);
    $display("test reset done");
    // two passes over every mode; stream modes stay unused
    for (int j = 0; j < 2; j++)
      for (int k = 0; k < 9; k++)
      begin
        cur = {$random(seed), 8'($random(seed))};
        wr(6'h02, cur.op_ctrl);
        wr(6'h05, cur.type_a);
        wr(6'h09, cur.aux);
        wr(6'h0a, cur.rx_one);
        wr(6'h0c, cur.rx_three);
        chk(o_cfg, cur);
        i_mode <= rpm_pkg::rpm_mode_t'(k[3:0]);
        i_rx_rate <= 3'(k + 4 * j);
        i_tx_rate <= 3'(j);
        ex = pre(cur, k[3:0], 3'(k + 4 * j), 3'(j));
        cmd(8'hcc);
        chk(o_cfg, ex);
        chk(o_cmd_term_irq, 1'b0);
        rd(6'h0a, d);
        chk(d, ex.rx_one);
      end
    rd(6'h3f, d);
    chk(d, 8'h00);
    wr(6'h3f, 8'hff);
    cmd(8'h55);
    chk(o_cfg, ex);
    $display("test preset done");
    wr(6'h02, 8'h40);
    cmd(8'hd0);
    chk({o_rx_on, o_framer_en, o_mask_tmr_clr}, 3'h0);
    i_mask_tmr_run <= 1'b1;
    cmd(8'hd1);
    chk({o_rx_on, o_framer_en, o_mask_tmr_clr, o_cmd_term_irq}, 4'he);
    i_mask_tmr_run <= 1'b0;
    cmd(8'hd1);
    chk(o_mask_tmr_clr, 1'b0);
    wr(6'h02, 8'h00);
    cmd(8'hd0);
    wr(6'h02, 8'h40);
    chk({o_rx_on, o_framer_en}, 2'h3);
    $display("test mask done");
    i_xtal_stable <= 1'b0;
    wr(6'h02, 8'hc0);
    cmd(8'hd3);
    chk({o_tx_on, o_amp_det_en, o_adc_abs}, 3'h0);
    i_xtal_stable <= 1'b1;
    wr(6'h02, 8'h40);
    cmd(8'hd3);
    chk({o_tx_on, o_amp_det_en, o_adc_abs}, 3'h0);
    wr(6'h02, 8'hc0);
    // 3 Vpp code first, then random codes and delays
    for (int t = 0; t < 4; t++)
    begin
      a_code <= (t == 0) ? 8'he6 : 8'($random(seed));
      a_dly  <= (t == 0) ? 8'h00 : 8'($random(seed)) & 8'h3f;
      cmd(8'hd3);
      chk({o_tx_on, o_amp_det_en, o_adc_abs}, 3'h7);
      cmd(8'hd0);
      chk(o_rx_on, 1'b1);
      wait_irq();
      chk({st, n < AMP}, 2'h3);
      chk({o_tx_on, o_amp_det_en, o_adc_abs}, 3'h0);
      rd(6'h25, d);
      chk(d, a_code);
    end
    mute <= 1'b1;
    cmd(8'hd3);
    wait_irq();
    chk({n >= AMP - 3, n <= AMP + 1}, 2'h3);
    rd(6'h25, d);
    chk(d, a_code);
    $display("test amplitude done");
    complete_run();
  end
endmodule // test_rpm_cmd
`default_nettype wire

// ### verilog/rpm_amp_meas.sv
// amplitude measurement sequencer: settle wait, conversion and result hold
`timescale 1ns/100ps
`default_nettype none
`include "rpm_map.svh"
module rpm_amp_meas #(
  parameter int AMP_MAX_CYC = `RPM_AMP_MAX_CYC
) (
  input  wire logic              i_sys_clk,  // device clock
  input  wire logic              i_rst,      // async reset, high
  input  wire logic              i_start,    // accepted measure pulse
  input  wire rpm_pkg::rpm_adc_t i_adc,      // converter result strobe
  output logic                   o_busy,     // measurement running
  output logic                   o_done,     // finish pulse
  output logic                   o_adc_start,// conversion request pulse
  output logic [7:0]             o_result    // held converter output
);
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV   = 3'b100
  } rpm_amp_st_t;

  rpm_amp_st_t state;
  logic [15:0] cnt;
  logic        finish;

  // give up at the time limit so the host never waits beyond it
  assign finish = (state == ST_CONV) &&
                  (i_adc.valid || cnt == 16'(AMP_MAX_CYC - 1));
  assign o_busy = (state != ST_IDLE);

  // sequencer and elapsed cycle count
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
    begin
      state       <= ST_IDLE;
      cnt         <= 16'h0000;
      o_adc_start <= 1'b0;
      o_done      <= 1'b0;
    end
    else
    begin
      o_adc_start <= 1'b0;
      o_done      <= finish;
      unique case (state)
        ST_IDLE:
          if (i_start)
          begin
            state <= ST_SETTLE;
            cnt   <= 16'h0000;
          end
        ST_SETTLE:
        begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(`RPM_AMP_SETTLE_CYC - 1))
          begin
            state       <= ST_CONV;
            o_adc_start <= 1'b1;
          end
        end
        ST_CONV:
        begin
          cnt <= cnt + 16'h0001;
          if (finish)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end

  // result stays until the next conversion overwrites it
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      o_result <= 8'h00;
    else if (state == ST_CONV && i_adc.valid)
      o_result <= i_adc.code;

  a_amp_time_max: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_busy |-> cnt < 16'(AMP_MAX_CYC))
    else $error("amplitude measurement overran its time limit");
  a_amp_hold_res: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(state == ST_CONV && i_adc.valid) |=> $stable(o_result))
    else $error("amplitude result changed without a conversion");
endmodule // rpm_amp_meas
`default_nettype wire

// ### verilog/rpm_cmd.sv
// direct command interpreter: analog preset, receive masking, amplitude measurement
`timescale 1ns/100ps
`default_nettype none
`include "rpm_map.svh"
module rpm_cmd #(
  parameter int AMP_MAX_CYC = `RPM_AMP_MAX_CYC
) (
  input  wire logic               i_sys_clk,       // device clock, 250 MHz
  input  wire logic               i_rst,           // async reset, high
  input  wire logic               i_reg_wr,        // register write strobe
  input  wire logic               i_reg_rd,        // register read strobe
  input  wire logic [5:0]         i_reg_addr,      // register offset
  input  wire logic [7:0]         i_reg_wdata,     // write data
  output logic [7:0]              o_reg_rdata,     // read data, registered
  input  wire rpm_pkg::rpm_cmd_t  i_cmd,           // direct command strobe
  input  wire rpm_pkg::rpm_mode_t i_mode,          // current mode definition
  input  wire logic [2:0]         i_rx_rate,       // rx bit rate code
  input  wire logic [2:0]         i_tx_rate,       // tx bit rate code
  input  wire logic               i_xtal_stable,   // oscillator frequency ok
  input  wire logic               i_mask_tmr_run,  // mask-receive timer running
  input  wire rpm_pkg::rpm_adc_t  i_adc,           // converter result strobe
  output logic                    o_mask_tmr_clr,  // mask timer reset pulse
  output logic                    o_rx_on,         // receive active (rssi/agc)
  output logic                    o_framer_en,     // receive framing enable
  output logic                    o_tx_on,         // transmitter on
  output logic                    o_amp_det_en,    // amplitude detector on
  output logic                    o_adc_abs,       // converter absolute, detector muxed
  output logic                    o_adc_start,     // conversion request pulse
  output logic                    o_cmd_term_irq,  // command termination pulse
  output rpm_pkg::rpm_cfg_t       o_cfg            // configuration registers
);
  logic [7:0] op_ctrl;
  logic [7:0] type_a;
  logic [7:0] aux;
  logic [7:0] rx_one;
  logic [7:0] rx_three;
  logic       rx_mask;
  logic       amp_busy;
  logic       amp_done;
  logic [7:0] amp_result;

  // command decode and acceptance
  logic is_nfc;
  logic is_target;
  logic cmd_preset;
  logic cmd_mask;
  logic cmd_unmask;
  logic cmd_amp;
  logic rx_enabled;
  logic amp_ok;

  assign is_nfc    = (i_mode == rpm_pkg::RPM_MODE_NFC_INIT) ||
                     (i_mode == rpm_pkg::RPM_MODE_NFC_TGT);
  assign is_target = (i_mode == rpm_pkg::RPM_MODE_NFC_TGT) ||
                     (i_mode == rpm_pkg::RPM_MODE_TGT_A) ||
                     (i_mode == rpm_pkg::RPM_MODE_TGT_DET);
  assign rx_enabled = op_ctrl[`RPM_OP_RXEN_BIT];
  assign amp_ok     = op_ctrl[`RPM_OP_EN_BIT] && i_xtal_stable;

  // no command is taken while a measurement runs, it cannot be chained
  assign cmd_preset = i_cmd.valid && !amp_busy &&
                      i_cmd.code == `RPM_CMD_PRESET;
  assign cmd_mask   = i_cmd.valid && !amp_busy && rx_enabled &&
                      i_cmd.code == `RPM_CMD_MASK;
  assign cmd_unmask = i_cmd.valid && !amp_busy && rx_enabled &&
                      i_cmd.code == `RPM_CMD_UNMASK;
  assign cmd_amp    = i_cmd.valid && !amp_busy && amp_ok &&
                      i_cmd.code == `RPM_CMD_AMP;

  // preset values, the stream modes are left to the host to avoid
  logic       mod_am;
  logic       mod_known;
  logic [5:0] filt;

  // modulation type: OOK for 106k styles, AM for B and 212/424 styles
  always_comb
  begin
    mod_known = 1'b1;
    mod_am    = 1'b0;
    unique case (i_mode)
      rpm_pkg::RPM_MODE_ISO_A,
      rpm_pkg::RPM_MODE_TYPE1:    mod_am = 1'b0;
      rpm_pkg::RPM_MODE_ISO_B,
      rpm_pkg::RPM_MODE_CARD_FL:  mod_am = 1'b1;
      rpm_pkg::RPM_MODE_NFC_INIT,
      rpm_pkg::RPM_MODE_NFC_TGT:  mod_am = (i_tx_rate != 3'h0);
      default:                    mod_known = 1'b0;
    endcase
  end

  // lowpass and zero mapping; nfc gets its own column, others by rate
  always_comb
  begin
    filt = 6'h00;
    if (is_nfc)
      filt = 6'h02;
    else
      unique case (i_rx_rate)
        3'h0:    filt = 6'h04;
        3'h1:    filt = 6'h0c;
        3'h2:    filt = 6'h14;
        3'h3:    filt = 6'h24;
        default: filt = 6'h00;
      endcase
  end

  // operation control: host writes, preset overrides two bits
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      op_ctrl <= 8'h00;
    else if (cmd_preset)
    begin
      if (is_nfc)
        op_ctrl[`RPM_OP_RXCHN_BIT] <= 1'b1;
      if (is_target || i_mode == rpm_pkg::RPM_MODE_NFC_INIT)
        op_ctrl[`RPM_OP_TXEN_BIT] <= 1'b0;
    end
    else if (i_reg_wr && i_reg_addr == `RPM_OFF_OP_CTRL)
      op_ctrl <= i_reg_wdata;

  // start byte insert in the type a / 106k settings
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      type_a <= 8'h00;
    else if (cmd_preset)
      type_a[`RPM_TA_F0_BIT] <= is_nfc;
    else if (i_reg_wr && i_reg_addr == `RPM_OFF_TYPE_A)
      type_a <= i_reg_wdata;

  // auxiliary definition: modulation type and field detector
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      aux <= 8'h00;
    else if (cmd_preset)
    begin
      if (mod_known)
        aux[`RPM_AUX_TRAM_BIT] <= mod_am;
      aux[`RPM_AUX_FD_BIT] <= is_nfc;
    end
    else if (i_reg_wr && i_reg_addr == `RPM_OFF_AUX)
      aux <= i_reg_wdata;

  // receiver setup one: channel, demodulator, filter
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      rx_one <= 8'h00;
    else if (cmd_preset)
    begin
      if (is_nfc)
        rx_one[`RPM_RX1_CHSEL_BIT] <= 1'b0;
      // rate codes above 848k need the mixer
      rx_one[`RPM_RX1_AMD_BIT] <= (i_rx_rate > 3'h3);
      rx_one[5:0]              <= filt;
    end
    else if (i_reg_wr && i_reg_addr == `RPM_OFF_RX_ONE)
      rx_one <= i_reg_wdata;

  // receiver setup three: clipping and forced gain cut
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      rx_three <= 8'h00;
    else if (cmd_preset)
    begin
      rx_three[`RPM_RX3_LIM_BIT]  <= is_nfc;
      rx_three[`RPM_RX3_GAIN_BIT] <= is_nfc;
    end
    else if (i_reg_wr && i_reg_addr == `RPM_OFF_RX_THREE)
      rx_three <= i_reg_wdata;

  // receive mask flag; no busy state so the next command can follow at once
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      rx_mask <= 1'b0;
    else if (cmd_mask)
      rx_mask <= 1'b1;
    else if (cmd_unmask)
      rx_mask <= 1'b0;

  // unmask cuts a running mask timer short
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      o_mask_tmr_clr <= 1'b0;
    else
      o_mask_tmr_clr <= cmd_unmask && i_mask_tmr_run;

  // receive path gating; masking only matters while rx is enabled
  assign o_rx_on     = rx_enabled && !rx_mask;
  assign o_framer_en = rx_enabled && !rx_mask;

  // measurement forces the transmitter without touching the enable bit
  assign o_tx_on      = op_ctrl[`RPM_OP_TXEN_BIT] || amp_busy;
  assign o_amp_det_en = amp_busy;
  assign o_adc_abs    = amp_busy;

  rpm_amp_meas #(
    .AMP_MAX_CYC (AMP_MAX_CYC)
  ) u_amp (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_start     (cmd_amp),
    .i_adc       (i_adc),
    .o_busy      (amp_busy),
    .o_done      (amp_done),
    .o_adc_start (o_adc_start),
    .o_result    (amp_result)
  );

  // only the measurement ends with a termination interrupt
  assign o_cmd_term_irq = amp_done;

  assign o_cfg = '{op_ctrl: op_ctrl, type_a: type_a, aux: aux,
                   rx_one: rx_one, rx_three: rx_three};

  // register read port, unmapped offsets read zero
  always_ff @(posedge i_sys_clk or posedge i_rst)
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
      unique case (i_reg_addr)
        `RPM_OFF_OP_CTRL:  o_reg_rdata <= op_ctrl;
        `RPM_OFF_TYPE_A:   o_reg_rdata <= type_a;
        `RPM_OFF_AUX:      o_reg_rdata <= aux;
        `RPM_OFF_RX_ONE:   o_reg_rdata <= rx_one;
        `RPM_OFF_RX_THREE: o_reg_rdata <= rx_three;
        `RPM_OFF_ADC_OUT:  o_reg_rdata <= amp_result;
        default:           o_reg_rdata <= 8'h00;
      endcase

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_preset_rx_chn: assert property (
    cmd_preset && is_nfc |=> op_ctrl[`RPM_OP_RXCHN_BIT])
    else $error("preset did not select single channel");
  a_preset_tx_off: assert property (
    cmd_preset && (is_target || i_mode == rpm_pkg::RPM_MODE_NFC_INIT)
    |=> !op_ctrl[`RPM_OP_TXEN_BIT] && !o_tx_on || amp_busy)
    else $error("preset left transmitter enabled");
  a_preset_nfc_rx: assert property (
    cmd_preset |=> type_a[`RPM_TA_F0_BIT] == $past(is_nfc) &&
    aux[`RPM_AUX_FD_BIT] == $past(is_nfc) && rx_three[1:0] == {2{$past(is_nfc)}})
    else $error("preset nfc bits wrong");
  a_mask_rx_off: assert property (
    cmd_mask |=> !o_rx_on && !o_framer_en)
    else $error("mask left receiver active");
  a_unmask_timer: assert property (
    cmd_unmask && i_mask_tmr_run |=> o_mask_tmr_clr && o_rx_on)
    else $error("unmask did not reset mask timer");
  a_mask_needs_rxen: assert property (
    !rx_enabled |=> $stable(rx_mask))
    else $error("mask flag moved with receiver disabled");
  a_amp_irq_only: assert property (
    o_cmd_term_irq |-> $past(amp_busy))
    else $error("termination interrupt without measurement");
  a_amp_accept: assert property (
    i_cmd.valid && i_cmd.code == `RPM_CMD_AMP && !amp_ok && !amp_busy
    |=> !amp_busy)
    else $error("measurement started without enable");
  a_amp_routing: assert property (
    cmd_amp |=> amp_busy && o_tx_on && o_amp_det_en && o_adc_abs)
    else $error("measurement routing not set");

  // preset bits named by mode and rate, checked against the mode inputs
  // ook styles must come out with the modulation bit cleared
  a_preset_ook_mod: assert property (
    cmd_preset && (i_mode == rpm_pkg::RPM_MODE_ISO_A || i_mode == rpm_pkg::RPM_MODE_TYPE1)
    |=> !aux[`RPM_AUX_TRAM_BIT])
    else $error("preset left modulation at am for ook mode");

  // type b and 212/424 card styles use am
  a_preset_am_mod: assert property (
    cmd_preset && (i_mode == rpm_pkg::RPM_MODE_ISO_B || i_mode == rpm_pkg::RPM_MODE_CARD_FL)
    |=> aux[`RPM_AUX_TRAM_BIT])
    else $error("preset left modulation at ook for am mode");

  // active nfc listens on the am channel
  a_preset_am_chan: assert property (
    cmd_preset && is_nfc |=> !rx_one[`RPM_RX1_CHSEL_BIT])
    else $error("preset did not pick the am channel");

  // peak detector up to 848k, mixer above
  a_preset_demod: assert property (
    cmd_preset |=> rx_one[`RPM_RX1_AMD_BIT] == ($past(i_rx_rate) > 3'h3))
    else $error("preset demodulator select wrong");

  // filter bits always follow the mapping of the accepted preset
  a_preset_filter: assert property (
    cmd_preset |=> rx_one[5:0] == $past(filt))
    else $error("preset filter bits wrong");

  // unmask opens both receive paths on the next cycle
  a_unmask_rx_on: assert property (
    cmd_unmask |=> o_rx_on && o_framer_en)
    else $error("unmask left receiver masked");

  // a disabled receiver is never reported active, mask or not
  a_rx_gate_en: assert property (
    !rx_enabled |-> !o_rx_on && !o_framer_en)
    else $error("receive active while receiver disabled");

  // the interrupt marks the end, the measurement no longer holds the front end
  a_irq_ends_busy: assert property (
    o_cmd_term_irq |-> !amp_busy)
    else $error("measurement still busy at termination interrupt");

  // a command other than preset never moves the configuration
  a_cfg_ignore: assert property (
    i_cmd.valid && !cmd_preset && !i_reg_wr |=> $stable(o_cfg))
    else $error("configuration changed by a non-preset command");
endmodule // rpm_cmd
`default_nettype wire

// ### verilog/rpm_map.svh
// register map, field positions and timing constants of the preset/mask/amplitude block
`ifndef RPM_MAP_SVH
`define RPM_MAP_SVH
`define RPM_OFF_OP_CTRL     6'h02
`define RPM_OFF_TYPE_A      6'h05
`define RPM_OFF_AUX         6'h09
`define RPM_OFF_RX_ONE      6'h0a
`define RPM_OFF_RX_THREE    6'h0c
`define RPM_OFF_ADC_OUT     6'h25
`define RPM_OP_EN_BIT       7
`define RPM_OP_RXEN_BIT     6
`define RPM_OP_RXCHN_BIT    5
`define RPM_OP_TXEN_BIT     3
`define RPM_TA_F0_BIT       5
`define RPM_AUX_TRAM_BIT    5
`define RPM_AUX_FD_BIT      4
`define RPM_RX1_CHSEL_BIT   7
`define RPM_RX1_AMD_BIT     6
`define RPM_RX3_LIM_BIT     1
`define RPM_RX3_GAIN_BIT    0
`define RPM_CMD_PRESET      8'hcc
`define RPM_CMD_MASK        8'hd0
`define RPM_CMD_UNMASK      8'hd1
`define RPM_CMD_AMP         8'hd3
`define RPM_START_BYTE      8'hf0
`define RPM_AMP_LSB_UVPP    13020
`define RPM_AMP_3VPP_CODE   8'he6
`define RPM_CLK_PERIOD_NS   4
`define RPM_AMP_MAX_NS      25000
`define RPM_AMP_MAX_CYC     (`RPM_AMP_MAX_NS / `RPM_CLK_PERIOD_NS)
`define RPM_AMP_SETTLE_CYC  64
`endif

// ### verilog/rpm_pkg.sv
// types shared by the preset/mask/amplitude block
package rpm_pkg;
  // mode definition codes as seen on the mode input
  typedef enum logic [3:0] {
    RPM_MODE_ISO_A     = 4'h0,
    RPM_MODE_ISO_B     = 4'h1,
    RPM_MODE_VICINITY  = 4'h2,
    RPM_MODE_CARD_FL   = 4'h3,
    RPM_MODE_TYPE1     = 4'h4,
    RPM_MODE_NFC_INIT  = 4'h5,
    RPM_MODE_NFC_TGT   = 4'h6,
    RPM_MODE_TGT_A     = 4'h7,
    RPM_MODE_TGT_DET   = 4'h8,
    RPM_MODE_SUB_STRM  = 4'he,
    RPM_MODE_BPSK_STRM = 4'hf
  } rpm_mode_t;

  // direct command strobe with its code
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } rpm_cmd_t;

  // converter result strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } rpm_adc_t;

  // configuration registers driven towards the analog front end
  typedef struct packed {
    logic [7:0] op_ctrl;
    logic [7:0] type_a;
    logic [7:0] aux;
    logic [7:0] rx_one;
    logic [7:0] rx_three;
  } rpm_cfg_t;
endpackage
